// file: design/mps_host.sv
// How it works
// - Quad mode: one pulse input, four phases a quarter period apart.
// - Single phase: second enable low, dual mode, second pulse input open.
// - Pulses are honoured only ten microseconds after primary enable rises.
// - Each phase switches between 200 kHz and 1.5 MHz; in quad mode periods under 16 give 12-cycle phases, 1.67 MHz.
// - Quad mode uses only fast tri-level signalling.
`timescale 1ns/1ns
module mps_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic primary_phase_enable,
  output logic second_phase_enable,
  output logic first_pulse_input_out,
  output logic first_pulse_input_oe,
  output logic second_pulse_input_out,
  output logic second_pulse_input_oe,
  output logic mode_strap_out,
  output logic mode_strap_oe,
  output logic fast_tri_level_signalling
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] clamp_phase(input logic [15:0] p);
    if (p < 16'(mps_pkg::PHASE_MIN_CYC))
      return 16'(mps_pkg::PHASE_MIN_CYC);
    else if (p > 16'(mps_pkg::PHASE_MAX_CYC))
      return 16'(mps_pkg::PHASE_MAX_CYC);
    else
      return p;
  endfunction : clamp_phase

  function automatic logic [1:0] mode_shift(input logic [1:0] m);
    case (m)
      mps_pkg::MPS_DOUBLER: return 2'h1;
      mps_pkg::MPS_QUAD: return 2'h2;
      default: return 2'h0;
    endcase
  endfunction : mode_shift

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [6:0] ctrl;
  logic [15:0] period;
  logic [15:0] duty;
  logic [1:0] mode_q;
  logic fast_q;
  mps_pkg::mps_state_e state;
  mps_pkg::mps_state_e next_state;
  logic [15:0] wake_cnt;
  logic [15:0] next_wake_cnt;

  wire access = psel && penable;
  wire do_write = access && pready && pwrite;
  wire hit_ctrl = (paddr == mps_pkg::CTRL_OFF);
  wire hit_period = (paddr == mps_pkg::PERIOD_OFF);
  wire hit_duty = (paddr == mps_pkg::DUTY_OFF);
  wire hit_status = (paddr == mps_pkg::STATUS_OFF);
  wire mapped = hit_ctrl || hit_period || hit_duty || hit_status;

  wire ctrl_en = ctrl[mps_pkg::CTRL_EN_BIT];
  wire [1:0] ctrl_mode = ctrl[mps_pkg::CTRL_MODE_LSB +: 2];
  wire ctrl_tri = ctrl[mps_pkg::CTRL_TRI_BIT];
  wire ctrl_single = ctrl[mps_pkg::CTRL_SINGLE_BIT];

  // Quad mode is forced to fast signalling
  wire want_fast = ctrl[mps_pkg::CTRL_FAST_BIT] || (ctrl_mode == mps_pkg::MPS_QUAD);
  // Single phase forces dual mode
  wire [1:0] want_mode = ctrl_single ? mps_pkg::MPS_DUAL : ctrl_mode;

  wire [15:0] phase_per = clamp_phase(period);
  wire clamped = (phase_per != period);
  // Input rate is phase rate times the number of phases served
  wire [15:0] in_per = phase_per >> mode_shift(mode_q);
  wire [15:0] in_high = (duty < in_per) ? duty : in_per - 16'h0001;

  wire [31:0] status_word = {24'h000000, clamped, fast_q, mode_q, state};
  wire [31:0] read_word = hit_ctrl ? {25'h0, ctrl} :
                          hit_period ? {16'h0000, period} :
                          hit_duty ? {16'h0000, duty} :
                          hit_status ? status_word : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= access && !pready;
      prdata <= (access && !pready && !pwrite) ? read_word : 32'h00000000;
      pslverr <= access && !pready && !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= mps_pkg::CTRL_RESET;
      period <= mps_pkg::PERIOD_RESET;
      duty <= mps_pkg::DUTY_RESET;
    end
    else if (do_write)
    begin
      if (hit_ctrl)
        ctrl <= pwdata[mps_pkg::CTRL_W-1:0];
      if (hit_period)
        period <= pwdata[15:0];
      if (hit_duty)
        duty <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Enable sequencing
  // ----------------------------------------------------------------
  wire wake_done = (wake_cnt >= 16'(mps_pkg::WAKE_CYCLES) - 16'h0001);

  always_comb
  begin
    next_state = state;
    next_wake_cnt = 16'h0000;
    case (state)
      mps_pkg::MPS_OFF:
        if (ctrl_en)
          next_state = mps_pkg::MPS_WAKE;
      mps_pkg::MPS_WAKE:
      begin
        next_wake_cnt = wake_cnt + 16'h0001;
        // Device ignores pulses until wake time has passed
        if (!ctrl_en)
          next_state = mps_pkg::MPS_OFF;
        else if (wake_done)
          next_state = ctrl_tri ? mps_pkg::MPS_TRI : mps_pkg::MPS_RUN;
      end
      mps_pkg::MPS_RUN:
        if (!ctrl_en)
          next_state = mps_pkg::MPS_OFF;
        else if (ctrl_tri)
          next_state = mps_pkg::MPS_TRI;
      mps_pkg::MPS_TRI:
        if (!ctrl_en)
          next_state = mps_pkg::MPS_OFF;
        else if (!ctrl_tri)
          next_state = mps_pkg::MPS_RUN;
      default:
        next_state = mps_pkg::MPS_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= mps_pkg::MPS_OFF;
      wake_cnt <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      wake_cnt <= next_wake_cnt;
    end
  end

  // Straps follow software only while the device is disabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= mps_pkg::MPS_DUAL;
      fast_q <= 1'b0;
    end
    else if (state == mps_pkg::MPS_OFF)
    begin
      mode_q <= want_mode;
      fast_q <= want_fast;
    end
  end

  // ----------------------------------------------------------------
  // Pulse generation
  // ----------------------------------------------------------------
  wire running = (state == mps_pkg::MPS_RUN);
  wire dual = (mode_q == mps_pkg::MPS_DUAL);
  wire pulse_a;
  wire pulse_b;

  // Leaving tri-state restarts the counters, so rotation resumes aligned
  mps_pulse_gen #(.CNT_W(mps_pkg::CNT_W)) u_gen_a (
    .pclk(pclk),
    .presetn(presetn),
    .run(running),
    .period(in_per),
    .high_time(in_high),
    .pulse(pulse_a)
  );

  // Second input used in dual mode only, in step with the first
  mps_pulse_gen #(.CNT_W(mps_pkg::CNT_W)) u_gen_b (
    .pclk(pclk),
    .presetn(presetn),
    .run(running && dual && !ctrl_single && (state == next_state)),
    .period(in_per),
    .high_time(in_high),
    .pulse(pulse_b)
  );

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      primary_phase_enable <= 1'b0;
      second_phase_enable <= 1'b0;
      first_pulse_input_out <= 1'b0;
      first_pulse_input_oe <= 1'b0;
      second_pulse_input_out <= 1'b0;
      second_pulse_input_oe <= 1'b0;
      mode_strap_out <= 1'b0;
      mode_strap_oe <= 1'b1;
      fast_tri_level_signalling <= 1'b0;
    end
    else
    begin
      primary_phase_enable <= (state != mps_pkg::MPS_OFF);
      // Second enable only in dual mode, never for single phase
      second_phase_enable <= dual && !ctrl_single && (state != mps_pkg::MPS_OFF);
      first_pulse_input_out <= running && pulse_a;
      // Released line reads as tri-state; pull-up brings fast mode high
      first_pulse_input_oe <= running;
      second_pulse_input_out <= running && dual && pulse_b;
      second_pulse_input_oe <= running && dual && !ctrl_single;
      mode_strap_out <= (mode_q == mps_pkg::MPS_DOUBLER);
      mode_strap_oe <= (mode_q != mps_pkg::MPS_QUAD);
      fast_tri_level_signalling <= fast_q;
    end
  end
endmodule : mps_host

// file: design/mps_pkg.sv
package mps_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned WAKE_NS = 10000;
  localparam int unsigned WAKE_CYCLES = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PHASE_FMAX_HZ = 1500000;
  localparam int unsigned PHASE_FMIN_HZ = 200000;
  localparam int unsigned PHASE_MIN_CYC = (CLK_HZ + PHASE_FMAX_HZ - 1) / PHASE_FMAX_HZ;
  localparam int unsigned PHASE_MAX_CYC = CLK_HZ / PHASE_FMIN_HZ;
  localparam int unsigned CNT_W = 16;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] PERIOD_OFF = 8'h04;
  localparam logic [7:0] DUTY_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0C;

  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_EN2_BIT = 1;
  localparam int unsigned CTRL_MODE_LSB = 2;
  localparam int unsigned CTRL_FAST_BIT = 4;
  localparam int unsigned CTRL_TRI_BIT = 5;
  localparam int unsigned CTRL_SINGLE_BIT = 6;
  localparam int unsigned CTRL_W = 7;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic [15:0] PERIOD_RESET = 16'h0028;
  localparam logic [15:0] DUTY_RESET = 16'h0004;

  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_MODE_LSB = 4;
  localparam int unsigned STAT_FAST_BIT = 6;
  localparam int unsigned STAT_CLAMP_BIT = 7;

  // ----------------------------------------------------------------
  // Driver modes, as driven on the mode strap
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MPS_DUAL = 2'h0,
    MPS_DOUBLER = 2'h1,
    MPS_QUAD = 2'h2
  } mps_mode_e;

  typedef enum logic [3:0] {
    MPS_OFF = 4'h1,
    MPS_WAKE = 4'h2,
    MPS_RUN = 4'h4,
    MPS_TRI = 4'h8
  } mps_state_e;
endpackage : mps_pkg

// file: design/mps_pulse_gen.sv
`timescale 1ns/1ns
module mps_pulse_gen #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [CNT_W-1:0] period,
  input wire logic [CNT_W-1:0] high_time,
  output logic pulse
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic wrap;

  assign wrap = (count >= period - CNT_W'(1));
  assign next_count = (!run || wrap) ? '0 : count + CNT_W'(1);

  // Restart at count zero so the first pulse follows each resume at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= '0;
      pulse <= 1'b0;
    end
    else
    begin
      count <= next_count;
      pulse <= run && (next_count < high_time);
    end
  end
endmodule : mps_pulse_gen

// file: test/mps_host_props.sv
`timescale 1ns/1ns
module mps_host_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic primary_phase_enable,
  input wire logic second_phase_enable,
  input wire logic first_pulse_input_oe,
  input wire logic second_pulse_input_oe,
  input wire logic mode_strap_out,
  input wire logic mode_strap_oe
);
  // ----------------------------------------
  // Port timing and gating checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  int unsigned wake_cnt;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      wake_cnt <= 0;
    else
      wake_cnt <= !primary_phase_enable ? 0 : (wake_cnt < 999 ? wake_cnt + 1 : wake_cnt);
  AST_PREADY_LAT: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready too long");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  AST_OE_NEEDS_EN: assert property (first_pulse_input_oe |-> primary_phase_enable)
    else $error("pulse driven while disabled");
  AST_WAKE_HOLD: assert property ($rose(first_pulse_input_oe) |-> wake_cnt >= 199)
    else $error("pulse before wake time");
  AST_SECOND_GATED: assert property (second_pulse_input_oe |->
    second_phase_enable && mode_strap_oe && !mode_strap_out)
    else $error("second pulse outside dual");
  AST_STRAP_HELD: assert property (primary_phase_enable && $past(primary_phase_enable)
    |-> $stable({mode_strap_out, mode_strap_oe}))
    else $error("strap moved while enabled");
  cover property ($rose(first_pulse_input_oe));
  cover property (pslverr);
  cover property (!mode_strap_oe && first_pulse_input_oe);
endmodule : mps_host_props
bind mps_host mps_host_props props_u (.pclk, .presetn, .psel, .penable, .prdata, .pready,
  .pslverr, .primary_phase_enable, .second_phase_enable, .first_pulse_input_oe,
  .second_pulse_input_oe, .mode_strap_out, .mode_strap_oe);

// file: test/mps_power_stage_model.sv
`timescale 1ns/1ns
module mps_power_stage_model (
  input wire logic pclk,
  input wire logic primary_phase_enable,
  input wire logic second_phase_enable,
  input wire logic first_pulse_input_out,
  input wire logic first_pulse_input_oe,
  input wire logic second_pulse_input_out,
  input wire logic second_pulse_input_oe,
  input wire logic mode_strap_out,
  input wire logic mode_strap_oe,
  output logic hi1,
  output logic lo1,
  output logic hi2,
  output logic lo2,
  output logic vdiv_on,
  output logic slave_link_line_a,
  output logic slave_link_line_b
);
  // ----------------------------------------
  // Strap latch, rotation, switch drive
  // ----------------------------------------
  logic [1:0] mode;
  logic [1:0] cur;
  logic [1:0] cnt;
  logic p1_q;
  logic single;
  logic after_tri;
  wire p1_tri = !first_pulse_input_oe;
  wire p1_hi = first_pulse_input_oe && first_pulse_input_out;
  wire want1 = p1_q && (mode == 2'h0 || single || (mode == 2'h1 ? !cur[0] : cur == 2'h0));
  wire want2 = mode == 2'h0 ? second_pulse_input_oe && second_pulse_input_out
    : p1_q && !single && (mode == 2'h1 ? cur[0] : cur == 2'h2);
  wire float1 = !primary_phase_enable || p1_tri;
  wire float2 = mode == 2'h0 ? !second_phase_enable || !second_pulse_input_oe
    : float1;
  always_ff @(posedge pclk)
  begin
    if (!primary_phase_enable)
    begin
      mode <= mode_strap_oe ? {1'b0, mode_strap_out} : 2'h2;
      cnt <= 2'h0;
      after_tri <= 1'b0;
      single <= 1'b0;
    end
    else if (p1_tri)
    begin
      cnt <= 2'h0;
      after_tri <= 1'b1;
      single <= 1'b1;
    end
    else if (p1_hi && !p1_q)
    begin
      cur <= after_tri ? 2'h0 : cnt;
      cnt <= after_tri ? 2'h1 : cnt + 2'h1;
      single <= after_tri;
      after_tri <= 1'b0;
    end
    p1_q <= p1_hi;
    hi1 <= !float1 && want1 && !lo1;
    lo1 <= !float1 && !want1 && !hi1;
    hi2 <= !float2 && want2 && !lo2;
    lo2 <= !float2 && !want2 && !hi2;
  end
  assign vdiv_on = primary_phase_enable;
  // Quad master holds the slave off while its input floats
  assign slave_link_line_a = (mode == 2'h2) && p1_tri;
  assign slave_link_line_b = (mode == 2'h2) && p1_tri;
endmodule : mps_power_stage_model

// file: test/multiphase_pulse_steering_test.sv
`timescale 1ns/1ns
module multiphase_pulse_steering_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic primary_phase_enable, second_phase_enable, first_pulse_input_out, first_pulse_input_oe;
  logic second_pulse_input_out, second_pulse_input_oe, mode_strap_out, mode_strap_oe;
  logic fast_tri_level_signalling, hi1, lo1, hi2, lo2, vdiv_on;
  logic slave_link_line_a, slave_link_line_b;
  int n_mismatch, checks_done;
  mps_host dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .primary_phase_enable, .second_phase_enable, .first_pulse_input_out,
    .first_pulse_input_oe, .second_pulse_input_out, .second_pulse_input_oe, .mode_strap_out,
    .mode_strap_oe, .fast_tri_level_signalling);
  mps_power_stage_model stage_u (.pclk, .primary_phase_enable, .second_phase_enable,
    .first_pulse_input_out, .first_pulse_input_oe, .second_pulse_input_out,
    .second_pulse_input_oe, .mode_strap_out, .mode_strap_oe, .hi1, .lo1, .hi2, .lo2, .vdiv_on,
    .slave_link_line_a, .slave_link_line_b);
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = !pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) n_mismatch++;
    if (n == 20) report_and_stop();
    @(posedge pclk);
  endtask : apb
  task automatic wait_oe();
    int n;
    for (n = 0; n < 400 && first_pulse_input_oe !== 1'b1; n++) @(posedge pclk);
    if (n == 400) n_mismatch++;
    if (n == 400) report_and_stop();
  endtask : wait_oe
  task automatic reset_values();
    logic [7:0] a [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    logic [31:0] e [5] = '{32'h0, 32'h28, 32'h4, 32'h1, 32'h0};
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    check(err, 32'h1);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, a[i], 32'h0);
      check(rd, e[i]);
      check(err, i == 4);
    end
    apb(1'b1, 8'h04, 32'h5);
    apb(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h81);
    apb(1'b1, 8'h04, 32'h28);
  endtask : reset_values
  task automatic run_mode(input logic [31:0] cfg, input logic [31:0] exp2);
    int c1, c2;
    logic q1, q2;
    apb(1'b1, 8'h00, cfg);
    apb(1'b1, 8'h00, cfg | 32'h1);
    repeat (4) @(posedge pclk);
    check({slave_link_line_a, slave_link_line_b}, cfg[3] ? 32'h3 : 32'h0);
    wait_oe();
    c1 = 0;
    c2 = 0;
    q1 = 1'b0;
    q2 = 1'b0;
    repeat (400)
    begin
      @(posedge pclk);
      c1 += hi1 && !q1;
      c2 += hi2 && !q2;
      q1 = hi1;
      q2 = hi2;
      if ((hi1 && lo1) || (hi2 && lo2)) check(32'h1, 32'h0);
    end
    check(32'(c1), 32'hA);
    check(32'(c2), exp2);
    check({slave_link_line_a, slave_link_line_b}, 32'h0);
    check(fast_tri_level_signalling, cfg[3]);
    apb(1'b1, 8'h00, 32'h0);
    repeat (4) @(posedge pclk);
    check({hi1, lo1, hi2, lo2, vdiv_on}, 32'h0);
  endtask : run_mode
  task automatic tri_fallback();
    apb(1'b1, 8'h00, 32'h04);
    apb(1'b1, 8'h00, 32'h05);
    wait_oe();
    apb(1'b1, 8'h00, 32'h09);
    apb(1'b0, 8'h0C, 32'h0);
    check(rd[5:4], 32'h1);
    apb(1'b1, 8'h00, 32'h25);
    repeat (3) @(posedge pclk);
    check({first_pulse_input_oe, hi1, lo1, hi2, lo2}, 32'h0);
    apb(1'b1, 8'h00, 32'h05);
    wait_oe();
    repeat (4) @(posedge pclk);
    check({hi1, hi2}, 32'h2);
    repeat (20) @(posedge pclk);
    check({hi1, hi2}, 32'h1);
    apb(1'b1, 8'h00, 32'h0);
  endtask : tri_fallback
  initial
  begin
    repeat (90000) @(posedge pclk);
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    reset_values();
    run_mode(32'h00, 32'hA);
    run_mode(32'h40, 32'h0);
    run_mode(32'h04, 32'hA);
    run_mode(32'h08, 32'hA);
    tri_fallback();
    report_and_stop();
  end
endmodule : multiphase_pulse_steering_test
